// >>> dfs_defines.vh
/*
  dfs_defines.vh - register offsets, fault codes, levels and timing constants
  for the drive fault supervisor.
  assumes: included by its bare name before any module that uses it.
*/
`ifndef DFS_DEFINES_VH
`define DFS_DEFINES_VH

// register byte offsets (word aligned)
`define DFS_REG_CTRL 8'h00
`define DFS_REG_CFG 8'h04
`define DFS_REG_WARN 8'h08
`define DFS_REG_ALARM 8'h0C
`define DFS_REG_STAT 8'h10
`define DFS_REG_LEVEL 8'h14

// ctrl fields (write 1 to act)
`define DFS_CTRL_RESET_BIT 0

// cfg fields
`define DFS_CFG_AUTORST_BIT 0
`define DFS_CFG_MOTOR_ALARM_BIT 1
`define DFS_CFG_THREE_PHASE_BIT 2
`define DFS_CFG_BRAKE_BIT 3
`define DFS_CFG_RESET 4'h4

// fault bit positions in warning and alarm words
`define DFS_F_LIVE_ZERO 0
`define DFS_F_PHASE_LOSS 1
`define DFS_F_VOLT_HIGH 2
`define DFS_F_VOLT_LOW 3
`define DFS_F_OVERVOLT 4
`define DFS_F_UNDERVOLT 5
`define DFS_F_INV_OVL 6
`define DFS_F_MOTOR_OVL 7
`define DFS_F_THERMISTOR 8
`define DFS_F_CUR_LIMIT 9
`define DFS_F_OVERCURRENT 10
`define DFS_F_EARTH 11
`define DFS_F_SWMODE 12
`define DFS_F_SHORT 13
`define DFS_F_SER_TIMEOUT 14
`define DFS_F_OPT_TIMEOUT 15
`define DFS_F_FREQ_RANGE 16
`define DFS_F_OPT_COMM 17
`define DFS_F_INRUSH 18
`define DFS_F_OVERTEMP 19
`define DFS_F_INTERNAL 20
`define DFS_F_TUNING 21
`define DFS_F_LOCKED 22
`define DFS_NFAULT 23

// class masks over the fault bits
`define DFS_WARN_CAPABLE 23'h4B_C7FF
`define DFS_ALARM_CAPABLE 23'h3E_FFF3
`define DFS_LOCK_CAPABLE 23'h14_3C33

// dc-link levels in volts
`define DFS_UV_LEVEL 10'd410
`define DFS_LOW_WARN 10'd440
`define DFS_HIGH_WARN 10'd765
`define DFS_HIGH_WARN_BRK 10'd800
`define DFS_OV_LEVEL 10'd820

// overload counter thresholds in percent
`define DFS_OVL_WARN 7'd98
`define DFS_OVL_TRIP 7'd100
`define DFS_OVL_RELEASE 7'd90

// timing: tick period in us and persistence delays in ms
`define DFS_CLK_MHZ 50
`define DFS_TICK_US 1000
`define DFS_TICK_CYC (`DFS_TICK_US * `DFS_CLK_MHZ)
`define DFS_HIGH_MS 5000
`define DFS_LOW_MS 2000
`define DFS_OV_MS 5000
`define DFS_UV_MS 2000
`define DFS_OFF_MS 500

`endif

// >>> dfs_supervisor.v
/*
  dfs_supervisor.v - drive fault supervisor: classifies faults, times dc-link
  excursions into trips, runs overload thresholds, gates reset sources and
  drives the warning/alarm indicators; avalon-mm slave for software.
  assumes: power-stage flags and pins are asynchronous and are synchronised
  here; the host bus is on i_mclk.
*/
//
// What this block does
// - warning shows only while its fault condition lasts
// - alarm keeps flashing after cause clears until an accepted reset
// - locked trip flashes both lamps; clears only after power cycle and reset
// - manual reset from panel key, digital input or serial command
// - automatic reset option selectable in configuration
// - motor thermal fault configurable as warning or alarm
// - trip coasts motor, both blink; fault gone leaves alarm blinking
// - accepted reset returns the drive to ready
// - codes 2,4,7,8,13 warn/alarm/lock; 9-12,17,18,34,36 warn/alarm
// - codes 14,15,16,35,37-45 alarm-only and locked
// - tuning codes alarm-only unlocked; codes 5,6,33,99 warning-only
// - live zero when analog input below half its minimum scaling
// - phase loss checked only on three-phase supply
// - above high warning: warn, trip overvoltage if persistent
// - below low warning: warn, trip undervoltage if persistent
// - above overvoltage limit inverter off, trip after delay
// - below undervoltage limit inverter off, trip after delay
// - power-down briefly shows low-voltage and undervoltage warnings together
// - overload counter warns at 98 percent, trips at 100 percent
// - overload trip not resettable until counter below 90 percent
// - alarm word readable as an accumulated set; warning and status words read live
`include "dfs_defines.vh"
`default_nettype none

module dfs_supervisor #(
  parameter TICK_CYC = `DFS_TICK_CYC
) (
  // clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // power-stage and monitor inputs (asynchronous)
  input wire [9:0] i_dc_link_voltage,
  input wire [11:0] i_analog_in,
  input wire [11:0] i_analog_min,
  input wire i_phase_loss,
  input wire [6:0] i_ovl_pct,
  input wire [`DFS_NFAULT-1:0] i_fault_raw,
  input wire i_mains_off,
  input wire i_mains_present,
  // reset sources (asynchronous)
  input wire i_key_reset,
  input wire i_din_reset,
  // avalon-mm slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // drive and indicators
  output reg o_inverter_en,
  output reg o_ready,
  output reg o_warn_led,
  output reg o_alarm_led
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: two flops before any logic reads a pin
  localparam SW = 10 + 24 + 1 + 7 + `DFS_NFAULT + 4;
  wire [SW-1:0] async_in;
  reg [SW-1:0] sync1_r;
  reg [SW-1:0] sync2_r;
  assign async_in = {i_dc_link_voltage, i_analog_in, i_analog_min, i_phase_loss, i_ovl_pct,
                     i_fault_raw, i_mains_off, i_mains_present, i_key_reset, i_din_reset};
  // multi-bit values may tear for one sample; dc-link trips only act after persistence
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r <= {SW{1'b0}};
      sync2_r <= {SW{1'b0}};
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end
  wire [9:0] dc_link_voltage = sync2_r[SW-1 -: 10];
  wire [11:0] ain = sync2_r[SW-11 -: 12];
  wire [11:0] amin = sync2_r[SW-23 -: 12];
  wire ph_loss = sync2_r[SW-35];
  wire [6:0] ovl = sync2_r[SW-36 -: 7];
  wire [`DFS_NFAULT-1:0] fraw = sync2_r[SW-43 -: `DFS_NFAULT];
  wire mains_off = sync2_r[3];
  wire mains_on = sync2_r[2];
  wire key_rst = sync2_r[1];
  wire din_rst = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////
  // configuration and software reset strobe
  reg [3:0] cfg_r;
  reg sw_reset_r;
  reg key_d_r;
  reg din_d_r;
  wire cfg_auto = cfg_r[`DFS_CFG_AUTORST_BIT];
  wire cfg_motor_alarm = cfg_r[`DFS_CFG_MOTOR_ALARM_BIT];
  wire cfg_3ph = cfg_r[`DFS_CFG_THREE_PHASE_BIT];
  wire cfg_brake = cfg_r[`DFS_CFG_BRAKE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // prescaled tick and persistence timers
  reg [31:0] presc_r;
  reg tick_r;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (presc_r >= TICK_CYC - 1) begin
      presc_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      presc_r <= presc_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // dc-link comparisons
  wire [9:0] high_lvl = cfg_brake ? `DFS_HIGH_WARN_BRK : `DFS_HIGH_WARN;
  wire c_high = dc_link_voltage > high_lvl;
  wire c_low = dc_link_voltage < `DFS_LOW_WARN;
  wire c_ov = dc_link_voltage > `DFS_OV_LEVEL;
  wire c_uv = dc_link_voltage < `DFS_UV_LEVEL;

  // one timer per condition; each restarts when its condition clears
  reg [15:0] t_high_r;
  reg [15:0] t_low_r;
  reg [15:0] t_ov_r;
  reg [15:0] t_uv_r;
  reg [15:0] t_off_r;
  wire exp_high = t_high_r >= `DFS_HIGH_MS;
  wire exp_low = t_low_r >= `DFS_LOW_MS;
  wire exp_ov = t_ov_r >= `DFS_OV_MS;
  wire exp_uv = t_uv_r >= `DFS_UV_MS;
  wire off_brief = mains_off && (t_off_r < `DFS_OFF_MS);
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t_high_r <= 16'h0000;
      t_low_r <= 16'h0000;
      t_ov_r <= 16'h0000;
      t_uv_r <= 16'h0000;
      t_off_r <= 16'h0000;
    end else begin
      t_high_r <= !c_high ? 16'h0000 : (tick_r && !exp_high) ? t_high_r + 16'h0001 : t_high_r;
      t_low_r <= !c_low ? 16'h0000 : (tick_r && !exp_low) ? t_low_r + 16'h0001 : t_low_r;
      t_ov_r <= !c_ov ? 16'h0000 : (tick_r && !exp_ov) ? t_ov_r + 16'h0001 : t_ov_r;
      t_uv_r <= !c_uv ? 16'h0000 : (tick_r && !exp_uv) ? t_uv_r + 16'h0001 : t_uv_r;
      t_off_r <= !mains_off ? 16'h0000 : (tick_r && off_brief) ? t_off_r + 16'h0001 : t_off_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live fault vector and classification
  reg [`DFS_NFAULT-1:0] cond;
  reg [`DFS_NFAULT-1:0] trip_now;
  always @* begin
    cond = fraw;
    cond[`DFS_F_LIVE_ZERO] = fraw[`DFS_F_LIVE_ZERO] | ({1'b0, ain} < {1'b0, amin[11:1]});
    cond[`DFS_F_PHASE_LOSS] = cfg_3ph & (ph_loss | fraw[`DFS_F_PHASE_LOSS]);
    cond[`DFS_F_VOLT_HIGH] = c_high;
    cond[`DFS_F_VOLT_LOW] = c_low | off_brief;
    cond[`DFS_F_OVERVOLT] = c_ov;
    cond[`DFS_F_UNDERVOLT] = c_uv | off_brief;
    cond[`DFS_F_INV_OVL] = ovl >= `DFS_OVL_WARN;
    // a fault trips only when its class allows an alarm
    trip_now = fraw & `DFS_ALARM_CAPABLE;
    trip_now[`DFS_F_LIVE_ZERO] = cond[`DFS_F_LIVE_ZERO] & fraw[`DFS_F_LIVE_ZERO];
    trip_now[`DFS_F_PHASE_LOSS] = cond[`DFS_F_PHASE_LOSS] & ph_loss;
    trip_now[`DFS_F_OVERVOLT] = exp_high | exp_ov;
    trip_now[`DFS_F_UNDERVOLT] = exp_low | exp_uv;
    trip_now[`DFS_F_INV_OVL] = ovl >= `DFS_OVL_TRIP;
    trip_now[`DFS_F_MOTOR_OVL] = fraw[`DFS_F_MOTOR_OVL] & cfg_motor_alarm;
    trip_now[`DFS_F_THERMISTOR] = fraw[`DFS_F_THERMISTOR] & cfg_motor_alarm;
  end
  // warnings are live only: no memory, they vanish with the cause
  wire [`DFS_NFAULT-1:0] warn_now = cond & `DFS_WARN_CAPABLE;

  ////////////////////////////////////////////////////////////////////////
  // latched alarms, lock, reset gating
  reg [`DFS_NFAULT-1:0] alarm_r;
  reg locked_r;
  reg power_cycled_r;
  wire key_edge = key_rst & ~key_d_r;
  wire din_edge = din_rst & ~din_d_r;
  wire manual_rst = key_edge | din_edge | sw_reset_r;
  wire auto_rst = cfg_auto & ~|(trip_now) & ~locked_r;
  wire ovl_block = alarm_r[`DFS_F_INV_OVL] & (ovl >= `DFS_OVL_RELEASE);
  // a locked trip needs a mains removal since it latched before reset counts
  wire lock_ok = ~locked_r | (power_cycled_r & mains_on);
  wire rst_accept = (manual_rst | auto_rst) & ~ovl_block & lock_ok & (|alarm_r);
  wire [`DFS_NFAULT-1:0] new_trip = trip_now & ~alarm_r;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_r <= {`DFS_NFAULT{1'b0}};
      locked_r <= 1'b0;
      power_cycled_r <= 1'b0;
      key_d_r <= 1'b0;
      din_d_r <= 1'b0;
    end else begin
      key_d_r <= key_rst;
      din_d_r <= din_rst;
      // a trip arriving with the reset wins over the clear
      if (rst_accept)
        alarm_r <= trip_now;
      else
        alarm_r <= alarm_r | trip_now;
      if (|(new_trip & `DFS_LOCK_CAPABLE))
        locked_r <= 1'b1;
      else if (rst_accept)
        locked_r <= 1'b0;
      if (!locked_r || rst_accept)
        power_cycled_r <= 1'b0;
      else if (mains_off)
        power_cycled_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicators: blink from the tick, inverter gating and ready
  reg [8:0] blink_r;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blink_r <= 9'h000;
      o_warn_led <= 1'b0;
      o_alarm_led <= 1'b0;
      o_inverter_en <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      if (tick_r)
        blink_r <= blink_r + 9'h001;
      // on a trip both blink while the cause is there; locked keeps both
      o_alarm_led <= (|alarm_r) & blink_r[8];
      o_warn_led <= ((|warn_now) | (|(alarm_r & trip_now)) | locked_r) & blink_r[8];
      // coast on any trip, and hold off while voltage is outside hard limits
      o_inverter_en <= ~(|alarm_r) & ~c_ov & ~c_uv & ~mains_off;
      o_ready <= ~(|alarm_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait state, answer at the second edge
  reg busy_r;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_r <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      cfg_r <= `DFS_CFG_RESET;
      sw_reset_r <= 1'b0;
    end else begin
      sw_reset_r <= 1'b0;
      if ((i_avs_read || i_avs_write) && !busy_r) begin
        busy_r <= 1'b1;
        o_avs_waitrequest <= 1'b0;
        if (i_avs_write) begin
          if (i_avs_address == `DFS_REG_CTRL)
            sw_reset_r <= i_avs_writedata[`DFS_CTRL_RESET_BIT];
          else if (i_avs_address == `DFS_REG_CFG)
            cfg_r <= i_avs_writedata[3:0];
        end
        if (i_avs_read) begin
          if (i_avs_address == `DFS_REG_CFG)
            o_avs_readdata <= {28'h000_0000, cfg_r};
          else if (i_avs_address == `DFS_REG_WARN)
            o_avs_readdata <= {9'h000, warn_now};
          else if (i_avs_address == `DFS_REG_ALARM)
            o_avs_readdata <= {9'h000, alarm_r};
          else if (i_avs_address == `DFS_REG_STAT)
            o_avs_readdata <= {25'h000_0000, ovl_block, lock_ok, power_cycled_r, locked_r,
                               o_inverter_en, o_ready, |alarm_r};
          else if (i_avs_address == `DFS_REG_LEVEL)
            o_avs_readdata <= {15'h0000, ovl, dc_link_voltage};
          else
            o_avs_readdata <= 32'h0000_0000;
        end
      end else begin
        busy_r <= 1'b0;
        o_avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> dfs_panel_model.sv
/* dfs_panel_model: operator panel stop/reset key and digital reset input.
   assumes: bench raises a request level once per press, on i_mclk. */
`default_nettype none
module dfs_panel_model (
  // clock and press requests
  input wire logic i_mclk,
  input wire logic i_key_req,
  input wire logic i_din_req,
  // reset pins towards the supervisor
  output logic o_key_reset,
  output logic o_din_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] key_sh = 6'h00;
  logic [5:0] din_sh = 6'h00;
  // a press lasts 5 cycles so the 2-flop sync sees a rise; released pins fall to their pull-down
  always @(posedge i_mclk) begin
    key_sh <= {key_sh[4:0], i_key_req};
    din_sh <= {din_sh[4:0], i_din_req};
  end
  assign o_key_reset = key_sh[0] & ~key_sh[5];
  assign o_din_reset = din_sh[0] & ~din_sh[5];
endmodule
`default_nettype wire

// >>> dfs_supervisor_checker.sv
/* dfs_supervisor_checker: port assertions for the fault supervisor.
   assumes: bound into every dfs_supervisor, one clock domain. */
`include "dfs_defines.vh"
`default_nettype none
module dfs_supervisor_checker #(
  parameter TICK_CYC = 4
) (
  // clock, reset and monitors
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [9:0] i_dc_link_voltage,
  input wire logic [6:0] i_ovl_pct,
  input wire logic i_mains_off,
  // bus and drive
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_inverter_en,
  input wire logic o_ready,
  input wire logic o_alarm_led
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  ////////////////////
  // bus answers come once, promptly, and only for a request
  a_wait_pulse: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_bound: assert property ((i_avs_read || i_avs_write) |-> ##[0:2] !o_avs_waitrequest)
    else $error("request not answered");
  a_wait_cause: assert property (!o_avs_waitrequest |-> $past(i_avs_read) || $past(i_avs_write))
    else $error("answer without request");
  a_rd_hold: assert property (!$stable(o_avs_readdata) |-> !o_avs_waitrequest && i_avs_read)
    else $error("read data moved outside a read");
  ////////////////////
  // four samples cover the input sync and the output register; the overload trip takes five for the alarm latch
  a_ov_cut: assert property ((i_dc_link_voltage > `DFS_OV_LEVEL)[*4] |=> !o_inverter_en)
    else $error("inverter on above overvoltage");
  a_uv_cut: assert property ((i_dc_link_voltage < `DFS_UV_LEVEL)[*4] |=> !o_inverter_en)
    else $error("inverter on below undervoltage");
  a_ovl_trip: assert property ((i_ovl_pct >= `DFS_OVL_TRIP)[*5] |=> !o_ready)
    else $error("ready at full overload");
  a_inv_run: assert property ((i_dc_link_voltage >= `DFS_LOW_WARN && i_dc_link_voltage <= `DFS_HIGH_WARN
    && o_ready && !i_mains_off)[*4] |-> o_inverter_en)
    else $error("inverter off in normal range");
  // the alarm lamp only ever lights with a latched alarm, which also drops ready
  a_led_alarm: assert property (o_alarm_led |-> !o_ready)
    else $error("alarm lamp lit while ready");
endmodule
bind dfs_supervisor dfs_supervisor_checker #(.TICK_CYC(TICK_CYC)) chk_u (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_dc_link_voltage(i_dc_link_voltage), .i_ovl_pct(i_ovl_pct),
  .i_mains_off(i_mains_off), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_inverter_en(o_inverter_en),
  .o_ready(o_ready), .o_alarm_led(o_alarm_led)
);
`default_nettype wire

// >>> dfs_supervisor_tb_top.sv
/* dfs_supervisor_tb_top: bus-level tests of the drive fault supervisor.
   assumes: design, checker and panel model compiled first; short tick. */
`include "dfs_defines.vh"
`default_nettype none
module dfs_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam logic [7:0] WA = `DFS_REG_WARN;
  localparam logic [7:0] AL = `DFS_REG_ALARM;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, pl = 0, kp = 0, dp = 0;
  logic key, din, wreq, inv, rdy, wled, aled;
  logic mon = 0, moff = 0;
  int aled_n = 0, wled_n = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [9:0] dc_link_voltage = 10'h0258;
  logic [11:0] ain = 12'h07D0;
  logic [6:0] ovl = 7'h00;
  logic [22:0] raw = 23'h00_0000;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // 50 MHz system clock
  always #10 clk = ~clk;
  dfs_supervisor #(.TICK_CYC(TK)) dut_u (
    .i_mclk(clk), .i_arst_n(rst_n), .i_dc_link_voltage(dc_link_voltage), .i_analog_in(ain),
    .i_analog_min(12'h03E8), .i_phase_loss(pl), .i_ovl_pct(ovl), .i_fault_raw(raw),
    .i_mains_off(moff), .i_mains_present(~moff), .i_key_reset(key), .i_din_reset(din),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_inverter_en(inv), .o_ready(rdy),
    .o_warn_led(wled), .o_alarm_led(aled)
  );
  // lamp cycle counts over a window that the tests open and close
  always @(posedge clk) begin
    if (!mon) begin
      aled_n <= 0;
      wled_n <= 0;
    end else begin
      aled_n <= aled_n + int'(aled);
      wled_n <= wled_n + int'(wled);
    end
  end
  dfs_panel_model pnl_u (.i_mclk(clk), .i_key_req(kp), .i_din_req(dp), .o_key_reset(key), .o_din_reset(din));
  ////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t ns saw %h expected %h", $time, seen, exp);
    end
  endtask
  // avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // settle n cycles, read, expect only bit b set (b < 0: none)
  task automatic rdchk(input int n, input logic [7:0] a, input int b);
    logic [31:0] seen;
    cyc(n);
    bus(1'b0, a, 32'h0000_0000);
    seen = rdat;
    chk(seen, (b < 0) ? 32'h0000_0000 : 32'h0000_0001 << b);
  endtask
  // mains removed for a few cycles; the brief switch-off warnings show meanwhile
  task automatic pwr_cycle();
    moff <= 1'b1;
    cyc(8);
    bus(1'b0, WA, 32'h0000_0000);
    chk(rdat, 32'h0000_0028);
    moff <= 1'b0;
    cyc(8);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////
  // hang guard, about 1.4 times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 48000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    rdchk(8, `DFS_REG_CFG, 2);
    rdchk(0, 8'h20, -1);
    chk(32'(rdy), 32'h0000_0001);
    ain <= 12'h01F3;
    rdchk(8, WA, 0);
    ain <= 12'h01F4;
    rdchk(8, WA, -1);
    pl <= 1'b1;
    rdchk(8, WA, 1);
    rdchk(0, AL, 1);
    bus(1'b1, `DFS_REG_CFG, 32'h0000_0000);
    rdchk(8, WA, -1);
    // phase loss trips locked: only a mains cycle and then a reset frees it
    pl <= 1'b0;
    pwr_cycle();
    bus(1'b1, `DFS_REG_CTRL, 32'h0000_0001);
    rdchk(4, AL, -1);
    raw <= 23'h01_0000;
    rdchk(8, WA, 16);
    raw <= 23'h00_0000;
    rdchk(8, WA, -1);
    $display("test warnings done");
    // with brake the high warning moves to 800 V, so 780 V stays quiet
    bus(1'b1, `DFS_REG_CFG, 32'h0000_0008);
    dc_link_voltage <= 10'h030C;
    rdchk(8, WA, -1);
    bus(1'b1, `DFS_REG_CFG, 32'h0000_0000);
    rdchk(TK * 2500, WA, 2);
    chk(32'(inv), 32'h0000_0001);
    dc_link_voltage <= 10'h0258;
    cyc(20);
    dc_link_voltage <= 10'h030C;
    rdchk(TK * 5000 - 300, AL, -1);
    rdchk(600, AL, 4);
    chk(32'(inv | rdy), 32'h0000_0000);
    dc_link_voltage <= 10'h0258;
    mon <= 1'b1;
    rdchk(2100, AL, 4);
    mon <= 1'b0;
    chk(32'(aled_n > 0), 32'h0000_0001);
    chk(32'(wled_n > 0), 32'h0000_0001);
    bus(1'b1, `DFS_REG_CTRL, 32'h0000_0001);
    rdchk(4, AL, 4);
    pwr_cycle();
    bus(1'b1, `DFS_REG_CTRL, 32'h0000_0001);
    rdchk(4, AL, -1);
    dc_link_voltage <= 10'h033E;
    cyc(8);
    chk(32'(inv), 32'h0000_0000);
    dc_link_voltage <= 10'h0190;
    cyc(8);
    chk(32'(inv), 32'h0000_0000);
    dc_link_voltage <= 10'h0258;
    cyc(8);
    chk(32'(inv), 32'h0000_0001);
    $display("test dc link done");
    ovl <= 7'h62;
    rdchk(8, WA, 6);
    rdchk(0, AL, -1);
    ovl <= 7'h64;
    rdchk(8, AL, 6);
    ovl <= 7'h5F;
    cyc(8);
    mon <= 1'b1;
    cyc(2100);
    mon <= 1'b0;
    chk(32'(aled_n > 0), 32'h0000_0001);
    chk(32'(wled_n), 32'h0000_0000);
    kp <= 1'b1;
    rdchk(12, AL, 6);
    ovl <= 7'h59;
    cyc(8);
    dp <= 1'b1;
    rdchk(12, AL, -1);
    chk(32'(rdy), 32'h0000_0001);
    bus(1'b1, `DFS_REG_CFG, 32'h0000_0001);
    ovl <= 7'h64;
    rdchk(8, AL, 6);
    ovl <= 7'h32;
    rdchk(12, AL, -1);
    raw <= 23'h00_0080;
    rdchk(8, AL, -1);
    bus(1'b1, `DFS_REG_CFG, 32'h0000_0003);
    rdchk(8, AL, 7);
    $display("test overload and resets done");
    summarize();
  end
endmodule
`default_nettype wire
